// ### hw/lrf_pkg.sv
/*
 * lrf_pkg: constants and types shared by the link response frame handler.
 * Assumes octet bit 1 of the link maps to bit 0 of every byte held here.
 */
package lrf_pkg;

    // apb byte offsets, one aligned word each
    localparam logic [7:0] LRF_OFS_CTRL = 8'h00; // control bits
    localparam logic [7:0] LRF_OFS_N201 = 8'h04; // maximum information length
    localparam logic [7:0] LRF_OFS_XID_DATA = 8'h08; // xid answer octets
    localparam logic [7:0] LRF_OFS_XID_LEN = 8'h0C; // xid answer length
    localparam logic [7:0] LRF_OFS_STATUS = 8'h10; // block state, read only
    localparam logic [7:0] LRF_OFS_REJECT = 8'h14; // last rejected control field, read only

    // control register bit positions
    localparam int LRF_CTRL_MF_ALLOWED = 0; // multiple frame operation possible
    localparam int LRF_CTRL_SET_BUSY = 1; // write 1 marks local busy reported by rnr
    localparam int LRF_CTRL_SEND_DM = 2; // write 1 sends one dm response
    localparam int LRF_CTRL_XID_INFO = 3; // answer xid with an information field

    // values after reset
    localparam logic LRF_RST_MF_ALLOWED = 1'b1;
    localparam logic [15:0] LRF_RST_N201 = 16'h0104; // 260 octets
    localparam logic [2:0] LRF_RST_XID_LEN = 3'h0;

    // control field encodings with the p/f bit cleared
    localparam logic [7:0] LRF_C_SABME = 8'h6F;
    localparam logic [7:0] LRF_C_DM = 8'h0F;
    localparam logic [7:0] LRF_C_UI = 8'h03;
    localparam logic [7:0] LRF_C_DISC = 8'h43;
    localparam logic [7:0] LRF_C_UA = 8'h63;
    localparam logic [7:0] LRF_C_FRMR = 8'h87;
    localparam logic [7:0] LRF_C_XID = 8'hAF;
    localparam int LRF_PF_BIT = 4; // p/f position in an unnumbered control octet

    // frame reject reason field
    localparam logic [15:0] LRF_FRMR_REASON_LEN = 16'h0005; // octets after control
    localparam logic [3:0] LRF_FRMR_LAST = 4'h5; // index of last octet sent

    // handler states
    typedef enum logic [1:0] {
        LRF_ST_IDLE = 2'b00,
        LRF_ST_SEND = 2'b01
    } lrf_state_t;

    // response kinds
    typedef enum logic [1:0] {
        LRF_K_UA = 2'b00,
        LRF_K_DM = 2'b01,
        LRF_K_FRMR = 2'b10,
        LRF_K_XID = 2'b11
    } lrf_kind_t;

    // action held back until the ua has left
    typedef enum logic [1:0] {
        LRF_A_NONE = 2'b00,
        LRF_A_SABME = 2'b01,
        LRF_A_DISC = 2'b10
    } lrf_act_t;

endpackage : lrf_pkg

// ### hw/lrf_handler.sv
/*
 * lrf_handler: checks each received frame descriptor, answers with ua, dm,
 * frmr or xid responses as an octet stream, and reports mode actions.
 * Assumes a framer upstream that delivers only frames with good fcs and
 * address, and a multiple frame engine that owns vs, va and vr on clk.
 */
// Functional notes
// - ua answers sabme/disc; act only after sent
// - ua carries no information field
// - sending ua clears local busy condition
// - dm, no information, when multiframe impossible
// - listed receive faults trigger frame reject
// - unlisted control encodings count as undefined
// - nr valid only within va to vs
// - frmr carries five reason octets after control
// - octets 5,6 rejected control; unnumbered pads zero
// - octet 7 holds vs, bit 1 zero
// - octet 8 holds vr and c/r
// - octet 9 holds w x y z, rest zero
// - w set for undefined control field
// - x for forbidden info or length; w too
// - y when info exceeds n201
// - z when control held invalid nr
// - xid command answered at once, no numbers
// - interpretable xid info gets info answer
// - uninterpretable or empty xid gets empty answer
// - xid information never exceeds n201
// - xid leaves mode and sequence variables alone
// - accepted sabme resets vs, va, vr
module lrf_handler
    import lrf_pkg::*;
#(
    parameter int SEQ_W = 7 // sequence number width, modulo 128
) (
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // received frame descriptor
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_ctrl1,
    input wire logic [7:0] rx_ctrl2,
    input wire logic rx_cr,
    input wire logic [15:0] rx_info_len,
    input wire logic rx_xid_ok,
    // sequence state of the multiple frame engine
    input wire logic [SEQ_W-1:0] vs,
    input wire logic [SEQ_W-1:0] va,
    input wire logic [SEQ_W-1:0] vr,
    // response octet stream
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_last,
    // actions for the multiple frame engine
    output logic seq_reset,
    output logic disc_done,
    output logic busy_cleared,
    output logic local_busy
);

    // whole state of the block
    typedef struct packed {
        lrf_state_t st;
        lrf_kind_t kind;
        lrf_act_t act;
        logic fbit; // f bit of the response
        logic [3:0] idx; // octet being offered
        logic [3:0] last; // index of final octet
        logic tx_valid;
        logic [7:0] tx_data;
        logic [7:0] rej1; // reason octet 5
        logic [7:0] rej2; // reason octet 6
        logic rej_cr;
        logic [3:0] flags; // z y x w
        logic [SEQ_W-1:0] cap_vs;
        logic [SEQ_W-1:0] cap_vr;
        logic mf_allowed;
        logic local_busy;
        logic xid_en;
        logic dm_req;
        logic [15:0] n201;
        logic [31:0] xid_data;
        logic [2:0] xid_len;
        logic [7:0] frmr_cnt;
        logic [31:0] prdata;
        logic pslverr;
        logic seq_reset;
        logic disc_done;
        logic busy_cleared;
    } lrf_reg_t;

    lrf_reg_t r;
    lrf_reg_t next_r;

    // decode of the offered frame
    logic is_i; // information frame
    logic is_s; // supervisory frame
    logic is_u; // unnumbered frame
    logic [7:0] umask; // unnumbered control without p/f
    logic defined;
    logic [SEQ_W-1:0] nr;
    logic [SEQ_W-1:0] nr_ofs;
    logic [SEQ_W-1:0] vs_ofs;
    logic flag_w;
    logic flag_x;
    logic flag_y;
    logic flag_z;
    logic pbit;
    logic no_info_kind; // unnumbered kinds that forbid information
    logic [2:0] xid_clamp;

    // octet selected for a given index of the current response
    function automatic logic [7:0] octet_at(input lrf_reg_t s, input logic [3:0] i);
        logic [7:0] o;
        o = 8'h00;
        case (s.kind)
            LRF_K_UA: o = {LRF_C_UA[7:5], s.fbit, LRF_C_UA[3:0]};
            LRF_K_DM: o = {LRF_C_DM[7:5], s.fbit, LRF_C_DM[3:0]};
            LRF_K_FRMR: begin
                case (i)
                    4'h0: o = {LRF_C_FRMR[7:5], s.fbit, LRF_C_FRMR[3:0]};
                    4'h1: o = s.rej1;
                    4'h2: o = s.rej2;
                    4'h3: o = {s.cap_vs, 1'b0};
                    4'h4: o = {s.cap_vr, s.rej_cr};
                    4'h5: o = {4'h0, s.flags};
                    default: o = 8'h00;
                endcase
            end
            LRF_K_XID: begin
                case (i)
                    4'h0: o = {LRF_C_XID[7:5], s.fbit, LRF_C_XID[3:0]};
                    4'h1: o = s.xid_data[7:0];
                    4'h2: o = s.xid_data[15:8];
                    4'h3: o = s.xid_data[23:16];
                    4'h4: o = s.xid_data[31:24];
                    default: o = 8'h00;
                endcase
            end
            default: o = 8'h00;
        endcase
        return o;
    endfunction : octet_at

    // classify the offered frame
    always_comb begin
        is_i = ~rx_ctrl1[0];
        is_s = (rx_ctrl1[1:0] == 2'b01);
        is_u = (rx_ctrl1[1:0] == 2'b11);
        umask = rx_ctrl1 & ~(8'h01 << LRF_PF_BIT);
        // only the listed encodings are defined
        defined = is_i
            | (is_s & (rx_ctrl1[7:4] == 4'h0) & (rx_ctrl1[3:2] != 2'b11))
            | (is_u & ((umask == LRF_C_SABME) | (umask == LRF_C_DM) | (umask == LRF_C_UI)
                | (umask == LRF_C_DISC) | (umask == LRF_C_UA) | (umask == LRF_C_FRMR)
                | (umask == LRF_C_XID)));
        nr = rx_ctrl2[7:1];
        // modulo distances from va make the window test wrap safely
        nr_ofs = nr - va;
        vs_ofs = vs - va;
        flag_z = defined & (is_i | is_s) & (nr_ofs > vs_ofs);
        no_info_kind = (umask == LRF_C_SABME) | (umask == LRF_C_DM) | (umask == LRF_C_DISC)
            | (umask == LRF_C_UA);
        flag_x = defined & ((is_s & (rx_info_len != 16'h0000))
            | (is_u & no_info_kind & (rx_info_len != 16'h0000))
            | (is_u & (umask == LRF_C_FRMR) & (rx_info_len != LRF_FRMR_REASON_LEN)));
        flag_y = defined & (is_i | (is_u & ((umask == LRF_C_UI) | (umask == LRF_C_XID))))
            & (rx_info_len > r.n201);
        flag_w = ~defined | flag_x;
        pbit = is_u ? rx_ctrl1[LRF_PF_BIT] : rx_ctrl2[0];
        // xid answer length limited by n201
        if ({13'h0000, r.xid_len} > r.n201) begin
            xid_clamp = r.n201[2:0];
        end else begin
            xid_clamp = r.xid_len;
        end
    end

    // next state of everything
    always_comb begin
        next_r = r;
        next_r.seq_reset = 1'b0;
        next_r.disc_done = 1'b0;
        next_r.busy_cleared = 1'b0;
        next_r.pslverr = 1'b0;

        // response engine
        case (r.st)
            LRF_ST_IDLE: begin
                if (rx_valid) begin
                    if (flag_w | flag_y | flag_z) begin
                        // every fault found goes into one reject
                        next_r.kind = LRF_K_FRMR;
                        next_r.flags = {flag_z, flag_y, flag_x, flag_w};
                        next_r.rej1 = rx_ctrl1;
                        next_r.rej2 = is_u ? 8'h00 : rx_ctrl2;
                        next_r.rej_cr = rx_cr;
                        next_r.cap_vs = vs;
                        next_r.cap_vr = vr;
                        next_r.fbit = pbit;
                        next_r.last = LRF_FRMR_LAST;
                        next_r.act = LRF_A_NONE;
                        next_r.frmr_cnt = r.frmr_cnt + 8'h01;
                        next_r.st = LRF_ST_SEND;
                    end else if (is_u & ~rx_cr & (umask == LRF_C_SABME)) begin
                        next_r.kind = r.mf_allowed ? LRF_K_UA : LRF_K_DM;
                        next_r.act = r.mf_allowed ? LRF_A_SABME : LRF_A_NONE;
                        next_r.fbit = pbit;
                        next_r.last = 4'h0;
                        next_r.st = LRF_ST_SEND;
                    end else if (is_u & ~rx_cr & (umask == LRF_C_DISC)) begin
                        next_r.kind = LRF_K_UA;
                        next_r.act = LRF_A_DISC;
                        next_r.fbit = pbit;
                        next_r.last = 4'h0;
                        next_r.st = LRF_ST_SEND;
                    end else if (is_u & ~rx_cr & (umask == LRF_C_XID)) begin
                        // the xid answer touches no mode or sequence state
                        next_r.kind = LRF_K_XID;
                        next_r.act = LRF_A_NONE;
                        next_r.fbit = pbit;
                        if (r.xid_en & rx_xid_ok & (rx_info_len != 16'h0000)) begin
                            next_r.last = {1'b0, xid_clamp};
                        end else begin
                            next_r.last = 4'h0;
                        end
                        next_r.st = LRF_ST_SEND;
                    end
                    // other frames belong to the multiple frame engine
                end else if (r.dm_req) begin
                    next_r.kind = LRF_K_DM;
                    next_r.act = LRF_A_NONE;
                    next_r.fbit = 1'b0;
                    next_r.last = 4'h0;
                    next_r.dm_req = 1'b0;
                    next_r.st = LRF_ST_SEND;
                end
                if (next_r.st == LRF_ST_SEND) begin
                    next_r.idx = 4'h0;
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data = octet_at(next_r, 4'h0);
                end
            end
            LRF_ST_SEND: begin
                if (tx_ready) begin
                    if (r.idx == r.last) begin
                        next_r.tx_valid = 1'b0;
                        next_r.st = LRF_ST_IDLE;
                        if (r.kind == LRF_K_UA) begin
                            // the mode change waits until the ua is out
                            next_r.seq_reset = (r.act == LRF_A_SABME);
                            next_r.disc_done = (r.act == LRF_A_DISC);
                            next_r.busy_cleared = r.local_busy;
                            next_r.local_busy = 1'b0;
                        end
                    end else begin
                        next_r.idx = r.idx + 4'h1;
                        next_r.tx_data = octet_at(r, r.idx + 4'h1);
                    end
                end
            end
            default: begin
                next_r.st = LRF_ST_IDLE;
                next_r.tx_valid = 1'b0;
            end
        endcase

        // apb read data is prepared in the setup cycle
        if (psel & ~penable) begin
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                LRF_OFS_CTRL: next_r.prdata = {28'h0000000, r.xid_en, 2'b00, r.mf_allowed};
                LRF_OFS_N201: next_r.prdata = {16'h0000, r.n201};
                LRF_OFS_XID_DATA: next_r.prdata = r.xid_data;
                LRF_OFS_XID_LEN: next_r.prdata = {29'h00000000, r.xid_len};
                LRF_OFS_STATUS: next_r.prdata = {16'h0000, r.frmr_cnt, r.flags,
                    r.dm_req, r.local_busy, r.st};
                LRF_OFS_REJECT: next_r.prdata = {15'h0000, r.rej_cr, r.rej2, r.rej1};
                default: next_r.pslverr = 1'b1; // unmapped address
            endcase
        end else if (psel & penable) begin
            next_r.pslverr = r.pslverr;
        end

        // apb writes take effect in the access cycle
        if (psel & penable & pwrite) begin
            case (paddr)
                LRF_OFS_CTRL: begin
                    next_r.mf_allowed = pwdata[LRF_CTRL_MF_ALLOWED];
                    next_r.xid_en = pwdata[LRF_CTRL_XID_INFO];
                    // a software set wins over a clear by ua in the same cycle
                    if (pwdata[LRF_CTRL_SET_BUSY]) begin
                        next_r.local_busy = 1'b1;
                    end
                    if (pwdata[LRF_CTRL_SEND_DM]) begin
                        next_r.dm_req = 1'b1;
                    end
                end
                LRF_OFS_N201: next_r.n201 = pwdata[15:0];
                LRF_OFS_XID_DATA: next_r.xid_data = pwdata;
                LRF_OFS_XID_LEN: next_r.xid_len = (pwdata[2:0] > 3'h4) ? 3'h4 : pwdata[2:0];
                default: next_r.dm_req = next_r.dm_req; // read-only or unmapped: ignored
            endcase
        end

        if (rst) begin
            next_r = '0;
            next_r.st = LRF_ST_IDLE;
            next_r.mf_allowed = LRF_RST_MF_ALLOWED;
            next_r.n201 = LRF_RST_N201;
            next_r.xid_len = LRF_RST_XID_LEN;
        end
    end

    // single state register
    always_ff @(posedge clk) begin
        r <= next_r;
    end

    // outputs
    assign rx_ready = (r.st == LRF_ST_IDLE); // one frame at a time; busy stalls the framer
    assign tx_valid = r.tx_valid;
    assign tx_data = r.tx_data;
    assign tx_last = r.tx_valid & (r.idx == r.last);
    assign prdata = r.prdata;
    assign pready = psel & penable;
    assign pslverr = r.pslverr & psel & penable;
    assign seq_reset = r.seq_reset;
    assign disc_done = r.disc_done;
    assign busy_cleared = r.busy_cleared;
    assign local_busy = r.local_busy;

endmodule : lrf_handler

// ### verification/lrf_handler_monitor.sv
/*
 * lrf_monitor: concurrent checks on the ports of lrf_handler.
 * Assumes one clock domain with a synchronous active high reset.
 */
module lrf_monitor
    import lrf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] rx_ctrl1,
    input wire logic rx_cr,
    input wire logic [15:0] rx_info_len,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic seq_reset,
    input wire logic disc_done,
    input wire logic busy_cleared,
    input wire logic local_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic first; // next octet opens a frame
    logic [2:0] cnt; // octets already taken in this frame
    logic in_frmr; // frame under way is a frame reject
    logic in_xid; // frame under way is an xid
    logic [7:0] code; // octet with p/f masked
    logic ua_end; // a lone ua octet leaves now
    logic xid_end; // last octet of an xid leaves now
    assign code = tx_data & 8'hEF;
    assign ua_end = tx_valid && tx_ready && tx_last && first && code == LRF_C_UA;
    assign xid_end = tx_valid && tx_ready && tx_last && (first ? code == LRF_C_XID : in_xid);
    // frame boundaries are taken from tx_last at each handshake, so the checks rely on tx_last being right
    always_ff @(posedge clk) begin
        if (rst) begin
            first <= 1'b1;
            cnt <= 3'h0;
            in_frmr <= 1'b0;
            in_xid <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            first <= tx_last;
            cnt <= tx_last ? 3'h0 : cnt + 3'h1;
            if (first) begin
                in_frmr <= code == LRF_C_FRMR;
                in_xid <= code == LRF_C_XID;
            end
        end
    end
    a_seq_after_ua: assert property (seq_reset |-> $past(ua_end))
        else $error("sequence reset without ua sent");
    a_disc_after_ua: assert property (disc_done |-> $past(ua_end))
        else $error("disconnect acted on before ua sent");
    a_clear_on_ua: assert property (busy_cleared |-> $past(ua_end) && $past(local_busy))
        else $error("busy clear without ua or busy");
    // a sabme with an information field is rightly rejected, so only a bare one must get ua or dm
    a_sabme_answer: assert property (rx_valid && rx_ready && !rx_cr && (rx_ctrl1 & 8'hEF) == LRF_C_SABME
        && rx_info_len == 16'h0000 |=> tx_valid && tx_last)
        else $error("sabme not answered next cycle");
    a_ua_dm_bare: assert property (tx_valid && first && (code == LRF_C_UA || code == LRF_C_DM) |-> tx_last)
        else $error("ua or dm carries more octets");
    a_frmr_five: assert property (tx_valid && tx_last && in_frmr && !first |-> cnt == 3'h5)
        else $error("frame reject reason not five octets");
    a_frmr_open: assert property (tx_valid && first && code == LRF_C_FRMR |-> !tx_last)
        else $error("frame reject without reason");
    a_vs_bit_zero: assert property (tx_valid && in_frmr && !first && cnt == 3'h3 |-> !tx_data[0])
        else $error("send state octet bit one set");
    a_flag_octet: assert property (tx_valid && in_frmr && !first && cnt == 3'h5 |->
        tx_data[7:4] == 4'h0 && (!tx_data[1] || tx_data[0]))
        else $error("flag octet malformed");
    // an xid over n201 is rightly rejected, and n201 is not visible here, so empty commands are watched
    a_xid_prompt: assert property (rx_valid && rx_ready && !rx_cr && (rx_ctrl1 & 8'hEF) == LRF_C_XID
        && rx_info_len == 16'h0000 |=> tx_valid && code == LRF_C_XID)
        else $error("xid not answered next cycle");
    a_xid_quiet: assert property (xid_end |=> !seq_reset && !disc_done)
        else $error("xid changed link mode");
endmodule : lrf_monitor

bind lrf_handler lrf_monitor i_lrf_monitor (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_ctrl1(rx_ctrl1), .rx_cr(rx_cr), .rx_info_len(rx_info_len), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .seq_reset(seq_reset), .disc_done(disc_done),
    .busy_cleared(busy_cleared), .local_busy(local_busy));

// ### verification/lrf_peer.sv
/*
 * lrf_peer: far link entity that takes response octets, promptly or slowly.
 * Assumes the handler's octet stream on the same clock.
 */
module lrf_peer (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [$]; // octets taken, emptied by the bench
    int frames = 0; // frames seen complete
    logic toggle = 1'b0; // slow mode accepts every other cycle
    // stalling exercises the hold of tx_data until taken
    always @(posedge clk) begin
        if (rst) begin
            tx_ready <= 1'b0;
        end else begin
            toggle <= ~toggle;
            tx_ready <= !slow || toggle;
            if (tx_valid && tx_ready) begin
                got.push_back(tx_data);
                frames <= frames + (tx_last ? 1 : 0);
            end
        end
    end
endmodule : lrf_peer

// ### verification/test_link_response_frame_handler.sv
/*
 * test_link_response_frame_handler: apb and frame descriptor stimulus with
 * checks of response octets and mode pulses.
 * Assumes lrf_peer collects octets and lrf_monitor is bound to the handler.
 */
module test_link_response_frame_handler
    import lrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_valid = 1'b0;
    logic rx_ready;
    logic [7:0] rx_ctrl1 = 8'h00;
    logic [7:0] rx_ctrl2 = 8'h00;
    logic rx_cr = 1'b0;
    logic [15:0] rx_info_len = 16'h0;
    logic rx_xid_ok = 1'b0;
    logic [6:0] vs = 7'h0A; // engine state held fixed
    logic [6:0] va = 7'h05;
    logic [6:0] vr = 7'h03;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] tx_data;
    logic tx_last;
    logic seq_reset;
    logic disc_done;
    logic busy_cleared;
    logic local_busy;
    logic slow = 1'b0; // peer stalls when set
    logic [31:0] rd; // last apb read data
    logic err; // last apb error flag
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_seq = 0; // running pulse totals
    int n_disc = 0;
    int n_clr = 0;
    lrf_handler i_lrf_handler (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_ctrl1(rx_ctrl1), .rx_ctrl2(rx_ctrl2), .rx_cr(rx_cr),
        .rx_info_len(rx_info_len), .rx_xid_ok(rx_xid_ok), .vs(vs), .va(va), .vr(vr), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .seq_reset(seq_reset),
        .disc_done(disc_done), .busy_cleared(busy_cleared), .local_busy(local_busy));
    lrf_peer i_lrf_peer (.clk(clk), .rst(rst), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // pulse totals and the hang limit
    always @(posedge clk) begin
        cycles <= cycles + 1;
        n_seq <= n_seq + (seq_reset === 1'b1 ? 1 : 0);
        n_disc <= n_disc + (disc_done === 1'b1 ? 1 : 0);
        n_clr <= n_clr + (busy_cleared === 1'b1 ? 1 : 0);
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // compares the collected octets, first octet in the low byte
    task automatic chk_frame(input string what, input int n, input logic [63:0] e);
        chk(what, n, i_lrf_peer.got.size());
        for (int i = 0; i < n && i < i_lrf_peer.got.size(); i++) begin
            chk(what, {24'h0, e[8*i+:8]}, {24'h0, i_lrf_peer.got[i]});
        end
        i_lrf_peer.got.delete();
    endtask : chk_frame
    // apb access; request held until the rising edge that sees pready, results taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb
    // waits for the response to leave and for any pulse to be counted
    task automatic drain();
        repeat (2) @(negedge clk);
        while (rx_ready !== 1'b1 || tx_valid !== 1'b0) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask : drain
    task automatic frame(input logic [7:0] c1, input logic [7:0] c2, input logic cr, input logic [15:0] len,
        input logic ok);
        @(posedge clk);
        rx_ctrl1 <= c1;
        rx_ctrl2 <= c2;
        rx_cr <= cr;
        rx_info_len <= len;
        rx_xid_ok <= ok;
        rx_valid <= 1'b1;
        @(negedge clk);
        while (rx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_ctrl1 <= ~c1; // stale descriptor must not look valid
        rx_ctrl2 <= ~c2;
        drain();
    endtask : frame
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, LRF_OFS_N201, 32'h0);
        chk("n201 reset", 32'h0104, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test registers done");
        slow <= 1'b1;
        apb(1'b1, LRF_OFS_CTRL, 32'h3);
        chk("busy set", 32'h1, {31'h0, local_busy});
        frame(8'h7F, 8'h00, 1'b0, 16'h0, 1'b0);
        chk_frame("ua", 1, 64'h73);
        chk("seq reset", 32'h1, n_seq);
        chk("busy clear", 32'h1, n_clr);
        chk("busy", 32'h0, {31'h0, local_busy});
        slow <= 1'b0;
        frame(8'h43, 8'h00, 1'b0, 16'h0, 1'b0);
        chk_frame("ua disc", 1, 64'h63);
        chk("disc", 32'h1, n_disc);
        $display("test mode setting done");
        apb(1'b1, LRF_OFS_CTRL, 32'h0);
        frame(8'h7F, 8'h00, 1'b0, 16'h0, 1'b0);
        chk_frame("dm", 1, 64'h1F);
        apb(1'b1, LRF_OFS_CTRL, 32'h4);
        drain();
        chk_frame("dm sw", 1, 64'h0F);
        chk("seq no mf", 32'h1, n_seq);
        apb(1'b1, LRF_OFS_CTRL, 32'h9);
        $display("test dm done");
        frame(8'hFF, 8'h00, 1'b1, 16'h0, 1'b0);
        chk_frame("frmr undef", 6, 64'h0107_1400_FF97);
        frame(8'h02, 8'h29, 1'b0, 16'h0105, 1'b0);
        chk_frame("frmr nr len", 6, 64'h0C06_1429_0297);
        frame(8'h01, 8'h14, 1'b0, 16'h0003, 1'b0);
        chk_frame("frmr s len", 6, 64'h0306_1414_0187);
        frame(8'h02, 8'h0A, 1'b0, 16'h0104, 1'b0);
        chk_frame("valid i", 0, 64'h0);
        $display("test frame reject done");
        slow <= 1'b1;
        apb(1'b1, LRF_OFS_XID_DATA, 32'h4433_2211);
        apb(1'b1, LRF_OFS_XID_LEN, 32'h3);
        frame(8'hBF, 8'h00, 1'b0, 16'h0004, 1'b1);
        chk_frame("xid info", 4, 64'h3322_11BF);
        apb(1'b1, LRF_OFS_N201, 32'h2);
        frame(8'hAF, 8'h00, 1'b0, 16'h0002, 1'b1);
        chk_frame("xid clamp", 3, 64'h2211_AF);
        frame(8'hAF, 8'h00, 1'b0, 16'h0002, 1'b0);
        chk_frame("xid unreadable", 1, 64'hAF);
        frame(8'hAF, 8'h00, 1'b0, 16'h0000, 1'b1);
        chk_frame("xid empty", 1, 64'hAF);
        chk("xid seq", 32'h1, n_seq);
        chk("xid disc", 32'h1, n_disc);
        chk("frames", 32'hB, i_lrf_peer.frames);
        $display("test xid done");
        complete_run();
    end
endmodule : test_link_response_frame_handler
